// *** design/exec_pkg.sv ***
package exec_pkg;

  // Operation selected by the instruction decoder.
  typedef enum logic [1:0] {
    OP_SUB_CARRY,
    OP_FIELD_EXTRACT,
    OP_DIVIDE
  } op_e;

  localparam int DATA_W   = 32;
  localparam int REG_W    = 4;
  localparam int NUM_REGS = 16;
  localparam int DIV_ITER = 32;

  // Register numbers that the wide subtract and field extract forms may not name; divide does not check them.
  localparam logic [3:0] REG_STACK = 4'hD;
  localparam logic [3:0] REG_PC    = 4'hF;

  // Field positions in the wide instruction word (first halfword in 31:16).
  localparam int WIDE_FIRST_LSB     = 16;
  localparam int WIDE_S_BIT         = 20;
  localparam int WIDE_UPPER_AMT_LSB = 12;
  localparam int WIDE_RD_LSB        = 8;
  localparam int WIDE_LOWER_AMT_LSB = 6;
  localparam int WIDE_TYPE_LSB      = 4;
  localparam int WIDE_SECOND_LSB    = 0;
  localparam int SIZE_LESS_ONE_LSB  = 0;

  // Field positions in the narrow instruction word (bits 15:0).
  localparam int NARROW_RDN_LSB    = 0;
  localparam int NARROW_SECOND_LSB = 3;

  // Shift type codes of the two-bit type field.
  localparam logic [1:0] SHIFT_LSL = 2'h0;
  localparam logic [1:0] SHIFT_LSR = 2'h1;
  localparam logic [1:0] SHIFT_ASR = 2'h2;
  localparam logic [1:0] SHIFT_ROR = 2'h3;

  // Bit positions of the program status flags.
  localparam int FLAG_N = 3;
  localparam int FLAG_Z = 2;
  localparam int FLAG_C = 1;
  localparam int FLAG_V = 0;
  localparam logic [3:0] FLAGS_RESET = 4'h0;

  localparam logic [4:0] TOP_BIT   = 5'h1F;
  localparam logic [5:0] MSB_LIMIT = 6'h1F;

endpackage

// *** design/signed_divide_seq.sv ***
`timescale 1ns/1ns
`default_nettype none

// Restoring divider on magnitudes, one quotient bit per clock.
module signed_divide_seq #(
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         nrst,
  // Request
  input  wire logic         start,
  input  wire logic [W-1:0] dividend,
  input  wire logic [W-1:0] divisor,
  // Answer
  output logic              done_q,
  output logic [W-1:0]      quotient_q
);

  logic [W:0]         rem_q;
  logic [W-1:0]       quo_q;
  logic [W-1:0]       dvs_q;
  logic               neg_q;
  logic               run_q;
  logic [7:0]         cnt_q;
  logic [W:0]         rem_shift;
  logic [W:0]         trial;
  logic               fits;
  logic [W-1:0]       quo_next;

  assign rem_shift = {rem_q[W-1:0], quo_q[W-1]};
  assign trial     = rem_shift - {1'b0, dvs_q};
  assign fits      = ~trial[W];
  assign quo_next  = {quo_q[W-2:0], fits};

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rem_q      <= '0;
      quo_q      <= '0;
      dvs_q      <= '0;
      neg_q      <= 1'b0;
      run_q      <= 1'b0;
      cnt_q      <= '0;
      done_q     <= 1'b0;
      quotient_q <= '0;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        rem_q <= '0;
        quo_q <= dividend[W-1] ? W'(-dividend) : dividend;
        dvs_q <= divisor[W-1] ? W'(-divisor) : divisor;
        neg_q <= dividend[W-1] ^ divisor[W-1];
        run_q <= 1'b1;
        cnt_q <= 8'(W);
      end else if (run_q) begin
        rem_q <= fits ? trial : rem_shift;
        quo_q <= quo_next;
        cnt_q <= cnt_q - 8'h01;
        if (cnt_q == 8'h01) begin
          run_q  <= 1'b0;
          done_q <= 1'b1;
          // Truncating the magnitude rounds toward zero; the most negative
          // value over minus one wraps to itself with no overflow report.
          quotient_q <= neg_q ? W'(-quo_next) : quo_next;
        end
      end
    end
  end

  AST_DIV_WRAP: assert property (@(posedge mclk) disable iff (!nrst)
    start && dividend == 32'h80000000 && divisor == 32'hFFFFFFFF |-> ##33 done_q && quotient_q == 32'h80000000)
    else $error("Most negative over minus one did not wrap.");

endmodule

`default_nettype wire

// *** design/subtract_carry_bitfield_divide.sv ***
`timescale 1ns/1ns
`default_nettype none

module subtract_carry_bitfield_divide (
  // Clock and reset
  input  wire logic            mclk,
  input  wire logic            nrst,
  // Issue from the decoder
  input  wire logic            issue_valid,
  input  wire exec_pkg::op_e   issue_op,
  input  wire logic            issue_narrow,
  input  wire logic [31:0]     issue_instr,
  input  wire logic            cond_pass,
  input  wire logic            in_cond_block,
  input  wire logic            div_trap_en,
  // Register and flag preload
  input  wire logic            load_en,
  input  wire logic [3:0]      load_reg,
  input  wire logic [31:0]     load_data,
  input  wire logic            flag_load_en,
  input  wire logic [3:0]      flag_load_nzcv,
  // Register observation
  input  wire logic [3:0]      peek_reg,
  output logic [31:0]          peek_data_q,
  // Completion
  output logic                 busy_q,
  output logic                 done_q,
  output logic                 wr_en_q,
  output logic [3:0]           wr_reg_q,
  output logic [31:0]          wr_data_q,
  output logic [3:0]           flags_q,
  output logic                 unpredictable_q,
  output logic                 div_zero_fault_q
);

  logic [31:0] regs_q [exec_pkg::NUM_REGS];
  logic [3:0]  div_dst_q;
  logic        setf_q;

  logic        accept;
  logic [3:0]  dst_reg;
  logic [3:0]  src_a_reg;
  logic [3:0]  src_b_reg;
  logic [1:0]  sh_type;
  logic [4:0]  imm5;
  logic [4:0]  sh_amt;
  logic [4:0]  wm1;
  logic        set_flags;
  logic        unpred;
  logic [31:0] opa;
  logic [31:0] opb;
  logic [31:0] sh_val;
  logic [32:0] sum;
  logic [31:0] sbc_res;
  logic        sbc_v;
  logic [5:0]  fx_msb;
  logic [31:0] fx_val;
  logic        div_zero;
  logic        div_start;
  logic        div_done;
  logic [31:0] div_quot;
  logic        ex_done;
  logic        ex_we;
  logic [3:0]  ex_reg;
  logic [31:0] ex_data;
  logic        ex_unpred;
  logic        ex_fault;
  logic        ex_setf;

  function automatic logic bad_reg(input logic [3:0] r);
    bad_reg = (r == exec_pkg::REG_STACK) || (r == exec_pkg::REG_PC);
  endfunction

  // An amount of zero means 32 for the right shifts and one-bit rotate
  // through carry for the rotate, as the immediate shift encoding does.
  function automatic logic [31:0] shift_operand(input logic [31:0] v, input logic [1:0] t,
                                                input logic [4:0] amt, input logic cin);
    logic [5:0] back;
    back = 6'h20 - {1'b0, amt};
    shift_operand = v;
    unique case (t)
      exec_pkg::SHIFT_LSL: shift_operand = v << amt;
      exec_pkg::SHIFT_LSR: shift_operand = (amt == '0) ? '0 : v >> amt;
      exec_pkg::SHIFT_ASR: shift_operand = (amt == '0) ? {32{v[31]}} : 32'($signed(v) >>> amt);
      exec_pkg::SHIFT_ROR: shift_operand = (amt == '0) ? {cin, v[31:1]} : ((v >> amt) | (v << back));
    endcase
  endfunction

  assign accept = issue_valid && !busy_q;
  assign imm5   = {issue_instr[exec_pkg::WIDE_UPPER_AMT_LSB +: 3], issue_instr[exec_pkg::WIDE_LOWER_AMT_LSB +: 2]};
  assign wm1    = issue_instr[exec_pkg::SIZE_LESS_ONE_LSB +: 5];

  // Field decode.
  always_comb begin
    dst_reg   = issue_instr[exec_pkg::WIDE_RD_LSB +: 4];
    src_a_reg = issue_instr[exec_pkg::WIDE_FIRST_LSB +: 4];
    src_b_reg = issue_instr[exec_pkg::WIDE_SECOND_LSB +: 4];
    sh_type   = issue_instr[exec_pkg::WIDE_TYPE_LSB +: 2];
    sh_amt    = imm5;
    set_flags = 1'b0;
    unpred    = 1'b0;
    unique case (issue_op)
      exec_pkg::OP_SUB_CARRY: begin
        if (issue_narrow) begin
          dst_reg   = {1'b0, issue_instr[exec_pkg::NARROW_RDN_LSB +: 3]};
          src_a_reg = {1'b0, issue_instr[exec_pkg::NARROW_RDN_LSB +: 3]};
          src_b_reg = {1'b0, issue_instr[exec_pkg::NARROW_SECOND_LSB +: 3]};
          sh_type   = exec_pkg::SHIFT_LSL;
          sh_amt    = '0;
          set_flags = !in_cond_block;
        end else begin
          set_flags = issue_instr[exec_pkg::WIDE_S_BIT];
          unpred    = bad_reg(dst_reg) || bad_reg(src_a_reg) || bad_reg(src_b_reg);
        end
      end
      exec_pkg::OP_FIELD_EXTRACT: begin
        unpred = bad_reg(dst_reg) || bad_reg(src_a_reg) || (fx_msb > exec_pkg::MSB_LIMIT);
      end
      exec_pkg::OP_DIVIDE: begin
        unpred = 1'b0;
      end
    endcase
  end

  assign opa    = regs_q[src_a_reg];
  assign opb    = regs_q[src_b_reg];
  assign sh_val = shift_operand(opb, sh_type, sh_amt, flags_q[exec_pkg::FLAG_C]);

  assign sum     = {1'b0, opa} + {1'b0, ~sh_val} + {32'h0, flags_q[exec_pkg::FLAG_C]};
  assign sbc_res = sum[31:0];
  assign sbc_v   = (opa[31] == ~sh_val[31]) && (sbc_res[31] != opa[31]);

  // Moving the field's top bit to bit 31 first lets one arithmetic shift
  // both align and sign extend it.
  assign fx_msb = {1'b0, imm5} + {1'b0, wm1};
  assign fx_val = 32'($signed(opa << (exec_pkg::TOP_BIT - fx_msb[4:0])) >>> (exec_pkg::TOP_BIT - wm1));

  assign div_zero  = (opb == '0);
  assign div_start = accept && issue_op == exec_pkg::OP_DIVIDE && cond_pass && !div_zero;

  signed_divide_seq #(
    .W (exec_pkg::DATA_W)
  ) u_div (
    .mclk       (mclk),
    .nrst       (nrst),
    .start      (div_start),
    .dividend   (opa),
    .divisor    (opb),
    .done_q     (div_done),
    .quotient_q (div_quot)
  );

  // Execution outcome of this cycle.
  always_comb begin
    ex_done   = 1'b0;
    ex_we     = 1'b0;
    ex_reg    = dst_reg;
    ex_data   = sbc_res;
    ex_unpred = 1'b0;
    ex_fault  = 1'b0;
    ex_setf   = 1'b0;
    if (div_done) begin
      ex_done = 1'b1;
      ex_we   = 1'b1;
      ex_reg  = div_dst_q;
      ex_data = div_quot;
    end else if (accept && !cond_pass) begin
      ex_done = 1'b1;
    end else if (accept) begin
      unique case (issue_op)
        exec_pkg::OP_SUB_CARRY: begin
          ex_done   = 1'b1;
          ex_unpred = unpred;
          ex_we     = !unpred;
          ex_setf   = !unpred && set_flags;
        end
        exec_pkg::OP_FIELD_EXTRACT: begin
          ex_done   = 1'b1;
          ex_unpred = unpred;
          ex_we     = !unpred;
          ex_data   = fx_val;
        end
        exec_pkg::OP_DIVIDE: begin
          if (div_zero) begin
            ex_done  = 1'b1;
            ex_fault = div_trap_en;
            ex_we    = !div_trap_en;
            ex_data  = '0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      done_q           <= 1'b0;
      wr_en_q          <= 1'b0;
      wr_reg_q         <= '0;
      wr_data_q        <= '0;
      unpredictable_q  <= 1'b0;
      div_zero_fault_q <= 1'b0;
      setf_q           <= 1'b0;
    end else begin
      done_q           <= ex_done;
      wr_en_q          <= ex_we;
      wr_reg_q         <= ex_reg;
      wr_data_q        <= ex_data;
      unpredictable_q  <= ex_unpred;
      div_zero_fault_q <= ex_fault;
      setf_q           <= ex_setf;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      busy_q    <= 1'b0;
      div_dst_q <= '0;
    end else if (div_start) begin
      busy_q    <= 1'b1;
      div_dst_q <= dst_reg;
    end else if (div_done) begin
      busy_q <= 1'b0;
    end
  end

  // Divide never reaches this path, so its flags stay as they were.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      flags_q <= exec_pkg::FLAGS_RESET;
    end else if (ex_setf) begin
      flags_q[exec_pkg::FLAG_N] <= sbc_res[31];
      flags_q[exec_pkg::FLAG_Z] <= (sbc_res == '0);
      flags_q[exec_pkg::FLAG_C] <= sum[32];
      flags_q[exec_pkg::FLAG_V] <= sbc_v;
    end else if (flag_load_en) begin
      flags_q <= flag_load_nzcv;
    end
  end

  // Results land in the file at the same edge, so a following instruction
  // reads them with no forwarding; an execution write beats a preload.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < exec_pkg::NUM_REGS; i++) begin
        regs_q[i] <= '0;
      end
    end else if (ex_we) begin
      regs_q[ex_reg] <= ex_data;
    end else if (load_en) begin
      regs_q[load_reg] <= load_data;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      peek_data_q <= '0;
    end else begin
      peek_data_q <= regs_q[peek_reg];
    end
  end

  AST_SBC_VALUE: assert property (@(posedge mclk) disable iff (!nrst)
    accept && cond_pass && issue_op == exec_pkg::OP_SUB_CARRY && !unpred
    |=> wr_en_q && wr_data_q == ($past(opa) - $past(sh_val) - ($past(flags_q[exec_pkg::FLAG_C]) ? 32'h0 : 32'h1)))
    else $error("Subtract with carry wrote a wrong value.");

  AST_SHIFT_LSR32: assert property (@(posedge mclk) disable iff (!nrst)
    !issue_narrow && issue_op == exec_pkg::OP_SUB_CARRY && sh_type == exec_pkg::SHIFT_LSR && sh_amt == '0
    |-> sh_val == '0)
    else $error("Logical right shift by zero did not act as 32.");

  AST_NARROW_DEST: assert property (@(posedge mclk) disable iff (!nrst)
    accept && cond_pass && issue_narrow && issue_op == exec_pkg::OP_SUB_CARRY
    |=> wr_en_q && wr_reg_q == {1'b0, $past(issue_instr[2:0])})
    else $error("Narrow form wrote the wrong register.");

  AST_IN_BLOCK_KEEPS: assert property (@(posedge mclk) disable iff (!nrst)
    accept && issue_narrow && in_cond_block && !flag_load_en |=> $stable(flags_q))
    else $error("Narrow form changed flags inside a conditional block.");

  AST_S_CLEAR_KEEPS: assert property (@(posedge mclk) disable iff (!nrst)
    accept && !issue_narrow && !issue_instr[20] && !flag_load_en |=> $stable(flags_q))
    else $error("Wide form without S changed the flags.");

  AST_SBC_BAD_REG: assert property (@(posedge mclk) disable iff (!nrst)
    accept && cond_pass && !issue_narrow && issue_op == exec_pkg::OP_SUB_CARRY
    && (issue_instr[11:8] == 4'hD || issue_instr[19:16] == 4'hF) |=> unpredictable_q && !wr_en_q)
    else $error("Forbidden register number was not refused.");

  AST_FLAG_NZ: assert property (@(posedge mclk) disable iff (!nrst)
    setf_q |-> flags_q[3] == wr_data_q[31] && flags_q[2] == (wr_data_q == 32'h0))
    else $error("N or Z does not match the written result.");

  AST_FIELD_SIGN: assert property (@(posedge mclk) disable iff (!nrst)
    accept && cond_pass && issue_op == exec_pkg::OP_FIELD_EXTRACT && !unpred
    |=> wr_en_q && wr_data_q[31] == $past(opa[fx_msb[4:0]]))
    else $error("Field was not sign extended from its top bit.");

  AST_FIELD_RANGE: assert property (@(posedge mclk) disable iff (!nrst)
    accept && cond_pass && issue_op == exec_pkg::OP_FIELD_EXTRACT && fx_msb > 6'h1F |=> unpredictable_q)
    else $error("Field beyond bit 31 was not refused.");

  AST_FIELD_BAD_REG: assert property (@(posedge mclk) disable iff (!nrst)
    accept && cond_pass && issue_op == exec_pkg::OP_FIELD_EXTRACT
    && (issue_instr[19:16] == 4'hD || issue_instr[11:8] == 4'hD) |=> unpredictable_q && !wr_en_q)
    else $error("Field extract used a forbidden register.");

  AST_DIV_FLAGS: assert property (@(posedge mclk) disable iff (!nrst)
    div_start |-> ##34 done_q && wr_en_q && !setf_q)
    else $error("Divide did not finish in time or touched the flags.");

  AST_DIV_ZERO: assert property (@(posedge mclk) disable iff (!nrst)
    accept && cond_pass && issue_op == exec_pkg::OP_DIVIDE && div_zero
    |=> done_q && (div_zero_fault_q ? !wr_en_q : (wr_en_q && wr_data_q == 32'h0)))
    else $error("Zero divisor handled wrongly.");

  AST_COND_FAIL: assert property (@(posedge mclk) disable iff (!nrst)
    accept && !cond_pass && !flag_load_en |=> done_q && !wr_en_q && $stable(flags_q))
    else $error("Failed condition changed state.");

endmodule

`default_nettype wire

// *** bench/subtract_carry_bitfield_divide_tb.sv ***
`timescale 1ns/1ns
`default_nettype none

module subtract_carry_bitfield_divide_tb;
  logic          mclk;
  logic          nrst;
  logic          issue_valid;
  exec_pkg::op_e issue_op;
  logic          issue_narrow;
  logic [31:0]   issue_instr;
  logic          cond_pass;
  logic          in_cond_block;
  logic          div_trap_en;
  logic          load_en;
  logic [3:0]    load_reg;
  logic [31:0]   load_data;
  logic          flag_load_en;
  logic [3:0]    flag_load_nzcv;
  logic [3:0]    peek_reg;
  logic [31:0]   peek_data_q;
  logic          busy_q;
  logic          done_q;
  logic          wr_en_q;
  logic [3:0]    wr_reg_q;
  logic [31:0]   wr_data_q;
  logic [3:0]    flags_q;
  logic          unpredictable_q;
  logic          div_zero_fault_q;
  int            miscompares;
  int            cmp_count;
  int            g_lat;
  logic          g_busy;
  logic          g_wr;
  logic          g_unp;
  logic          g_fault;
  logic [3:0]    g_reg;
  logic [31:0]   g_data;
  logic [3:0]    g_flags;
  logic [31:0]   g_peek;
  logic [3:0]    f;

  subtract_carry_bitfield_divide dut (
    .mclk(mclk), .nrst(nrst), .issue_valid(issue_valid), .issue_op(issue_op), .issue_narrow(issue_narrow),
    .issue_instr(issue_instr), .cond_pass(cond_pass), .in_cond_block(in_cond_block), .div_trap_en(div_trap_en),
    .load_en(load_en), .load_reg(load_reg), .load_data(load_data), .flag_load_en(flag_load_en),
    .flag_load_nzcv(flag_load_nzcv), .peek_reg(peek_reg), .peek_data_q(peek_data_q), .busy_q(busy_q),
    .done_q(done_q), .wr_en_q(wr_en_q), .wr_reg_q(wr_reg_q), .wr_data_q(wr_data_q), .flags_q(flags_q),
    .unpredictable_q(unpredictable_q), .div_zero_fault_q(div_zero_fault_q)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic cmp_w(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_b(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Subtract with carry as {N,Z,C,V,result}.
  function automatic logic [35:0] subtract_with_carry(input logic [31:0] a, input logic [31:0] b, input logic cin);
    logic [32:0] s;
    logic        v;
    s = {1'b0, a} + {1'b0, ~b} + {32'h0, cin};
    v = (a[31] == ~b[31]) && (s[31] != a[31]);
    return {s[31], s[31:0] == 32'h0, s[32], v, s[31:0]};
  endfunction

  function automatic logic [31:0] wide(input logic [3:0] rn, input logic s, input logic [4:0] amt,
                                       input logic [3:0] rd, input logic [1:0] t, input logic [3:0] rm);
    return {11'h0, s, rn, 1'b0, amt[4:2], rd, amt[1:0], t, rm};
  endfunction

  task automatic load(input logic [3:0] r, input logic [31:0] v);
    @(posedge mclk);
    load_en <= 1'b1;
    load_reg <= r;
    load_data <= v;
    @(posedge mclk);
    load_en <= 1'b0;
  endtask

  task automatic set_flags(input logic [3:0] v);
    @(posedge mclk);
    flag_load_en <= 1'b1;
    flag_load_nzcv <= v;
    @(posedge mclk);
    flag_load_en <= 1'b0;
    f = v;
  endtask

  task automatic peek(input logic [3:0] r);
    @(posedge mclk);
    peek_reg <= r;
    repeat (2) @(posedge mclk);
    #1;
    g_peek = peek_data_q;
  endtask

  // Issues one instruction and waits for its completion pulse.
  task automatic run(input exec_pkg::op_e op, input logic nar, input logic [31:0] ins, input logic cp,
                     input logic blk, input logic trap);
    @(posedge mclk);
    issue_valid <= 1'b1;
    issue_op <= op;
    issue_narrow <= nar;
    issue_instr <= ins;
    cond_pass <= cp;
    in_cond_block <= blk;
    div_trap_en <= trap;
    @(posedge mclk);
    issue_valid <= 1'b0;
    #1;
    g_busy = busy_q;
    g_lat = 0;
    while (done_q !== 1'b1 && g_lat < 40) begin
      @(posedge mclk);
      #1;
      g_lat++;
    end
    cmp_b(done_q, 1'b1);
    g_wr = wr_en_q;
    g_reg = wr_reg_q;
    g_data = wr_data_q;
    g_unp = unpredictable_q;
    g_fault = div_zero_fault_q;
    g_flags = flags_q;
  endtask

  task automatic t_narrow;
    logic [35:0] e;
    load(4'h1, 32'h0000_0005);
    load(4'h2, 32'h0000_0005);
    set_flags(4'h2);
    e = subtract_with_carry(32'h5, 32'h5, 1'b1);
    run(exec_pkg::OP_SUB_CARRY, 1'b1, {26'h0, 3'h2, 3'h1}, 1'b1, 1'b0, 1'b0);
    cmp_w({27'h0, g_wr, g_reg}, 32'h11);
    cmp_w(g_data, e[31:0]);
    cmp_w({28'h0, g_flags}, {28'h0, e[35:32]});
    f = e[35:32];
    e = subtract_with_carry(e[31:0], 32'h5, f[1]);
    run(exec_pkg::OP_SUB_CARRY, 1'b1, {26'h0, 3'h2, 3'h1}, 1'b1, 1'b1, 1'b0);
    cmp_w(g_data, e[31:0]);
    cmp_w({28'h0, g_flags}, {28'h0, f});
    peek(4'h1);
    cmp_w(g_peek, e[31:0]);
  endtask

  task automatic t_wide;
    logic [31:0] b;
    logic [31:0] sh;
    logic [35:0] e;
    b = 32'hF000_0013;
    load(4'h3, 32'h8000_0000);
    load(4'h4, b);
    set_flags(4'h0);
    for (int i = 0; i < 4; i++) begin
      case (i)
        0: sh = b << 4;
        1: sh = b >> 4;
        2: sh = $unsigned($signed(b) >>> 4);
        default: sh = {b[3:0], b[31:4]};
      endcase
      e = subtract_with_carry(32'h8000_0000, sh, f[1]);
      run(exec_pkg::OP_SUB_CARRY, 1'b0, wide(4'h3, 1'b1, 5'h04, 4'h5, i[1:0], 4'h4), 1'b1, 1'b1, 1'b0);
      cmp_w(g_data, e[31:0]);
      cmp_w({28'h0, g_reg}, 32'h5);
      cmp_w({28'h0, g_flags}, {28'h0, e[35:32]});
      f = e[35:32];
    end
    e = subtract_with_carry(32'h8000_0000, $unsigned($signed(b) >>> 8), f[1]);
    run(exec_pkg::OP_SUB_CARRY, 1'b0, wide(4'h3, 1'b0, 5'h08, 4'h5, 2'h2, 4'h4), 1'b1, 1'b0, 1'b0);
    cmp_w(g_data, e[31:0]);
    cmp_w({28'h0, g_flags}, {28'h0, f});
    // A logical right shift with a zero amount field shifts by 32.
    e = subtract_with_carry(32'h8000_0000, 32'h0, f[1]);
    run(exec_pkg::OP_SUB_CARRY, 1'b0, wide(4'h3, 1'b0, 5'h00, 4'h5, 2'h1, 4'h4), 1'b1, 1'b0, 1'b0);
    cmp_w(g_data, e[31:0]);
  endtask

  task automatic t_unpred;
    logic [3:0]  rn[4] = '{4'hD, 4'h3, 4'h3, 4'hF};
    logic [3:0]  rd[4] = '{4'h5, 4'hF, 4'h5, 4'h5};
    logic [3:0]  rm[4] = '{4'h4, 4'h4, 4'hD, 4'hF};
    for (int i = 0; i < 4; i++) begin
      run(exec_pkg::OP_SUB_CARRY, 1'b0, wide(rn[i], 1'b1, 5'h00, rd[i], 2'h0, rm[i]), 1'b1, 1'b0, 1'b0);
      cmp_b(g_unp & ~g_wr, 1'b1);
      cmp_w({28'h0, g_flags}, {28'h0, f});
    end
    run(exec_pkg::OP_FIELD_EXTRACT, 1'b0, wide(4'h6, 1'b0, 5'h00, 4'hD, 2'h0, 4'h3), 1'b1, 1'b0, 1'b0);
    cmp_b(g_unp & ~g_wr, 1'b1);
    run(exec_pkg::OP_FIELD_EXTRACT, 1'b0, wide(4'h6, 1'b0, 5'h1E, 4'h7, 2'h0, 4'h2), 1'b1, 1'b0, 1'b0);
    cmp_b(g_unp & ~g_wr, 1'b1);
  endtask

  task automatic t_extract;
    logic [4:0]  lsb[5] = '{5'h08, 5'h00, 5'h1F, 5'h04, 5'h1D};
    logic [4:0]  sz[5]  = '{5'h03, 5'h1F, 5'h00, 5'h03, 5'h02};
    logic [31:0] ex[5]  = '{32'hFFFF_FFFA, 32'hA5A0_0A00, 32'hFFFF_FFFF, 32'h0, 32'hFFFF_FFFD};
    load(4'h6, 32'hA5A0_0A00);
    for (int i = 0; i < 5; i++) begin
      run(exec_pkg::OP_FIELD_EXTRACT, 1'b0, wide(4'h6, 1'b0, lsb[i], 4'h7, {1'b0, sz[i][4]}, sz[i][3:0]),
          1'b1, 1'b0, 1'b0);
      cmp_w(g_data, ex[i]);
      cmp_b(g_wr & ~g_unp, 1'b1);
    end
  endtask

  task automatic t_divide;
    logic [31:0] n[4] = '{32'h7, 32'hFFFF_FFF9, 32'h8000_0000, 32'h64};
    logic [31:0] d[4] = '{32'h2, 32'h2, 32'hFFFF_FFFF, 32'hFFFF_FFF9};
    logic [31:0] q[4] = '{32'h3, 32'hFFFF_FFFD, 32'h8000_0000, 32'hFFFF_FFF2};
    set_flags(4'h9);
    for (int i = 0; i < 4; i++) begin
      load(4'h8, n[i]);
      load(4'h9, d[i]);
      run(exec_pkg::OP_DIVIDE, 1'b0, wide(4'h8, 1'b0, 5'h00, 4'hA, 2'h0, 4'h9), 1'b1, 1'b0, 1'b0);
      cmp_w(g_lat, 32'h21);
      cmp_b(g_busy, 1'b1);
      cmp_w(g_data, q[i]);
      cmp_b(g_unp | g_fault, 1'b0);
      cmp_w({28'h0, g_flags}, 32'h9);
    end
    load(4'h9, 32'h0);
    run(exec_pkg::OP_DIVIDE, 1'b0, wide(4'h8, 1'b0, 5'h00, 4'hA, 2'h0, 4'h9), 1'b1, 1'b0, 1'b0);
    cmp_w({g_wr, g_fault, g_data[29:0]}, 32'h8000_0000);
    run(exec_pkg::OP_DIVIDE, 1'b0, wide(4'h8, 1'b0, 5'h00, 4'hA, 2'h0, 4'h9), 1'b1, 1'b0, 1'b1);
    cmp_w({30'h0, g_wr, g_fault}, 32'h1);
  endtask

  task automatic t_cond_fail;
    load(4'h5, 32'h1234_5678);
    run(exec_pkg::OP_SUB_CARRY, 1'b0, wide(4'h3, 1'b1, 5'h00, 4'h5, 2'h0, 4'h4), 1'b0, 1'b0, 1'b0);
    cmp_b(g_wr, 1'b0);
    cmp_w({28'h0, g_flags}, {28'h0, f});
    peek(4'h5);
    cmp_w(g_peek, 32'h1234_5678);
  endtask

  initial begin
    miscompares = 0;
    cmp_count = 0;
    nrst = 1'b0;
    issue_valid = 1'b0;
    issue_op = exec_pkg::OP_SUB_CARRY;
    issue_narrow = 1'b0;
    issue_instr = 32'h0;
    cond_pass = 1'b1;
    in_cond_block = 1'b0;
    div_trap_en = 1'b0;
    load_en = 1'b0;
    load_reg = 4'h0;
    load_data = 32'h0;
    flag_load_en = 1'b0;
    flag_load_nzcv = 4'h0;
    peek_reg = 4'h0;
    f = 4'h0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    peek(4'h0);
    cmp_w(g_peek, 32'h0);
    cmp_w({27'h0, busy_q, flags_q}, 32'h0);
    t_narrow();
    t_wide();
    t_unpred();
    t_extract();
    t_divide();
    t_cond_fail();
    close_out();
  end

  // The whole sequence needs well under a thousand cycles.
  initial begin
    #50000;
    miscompares++;
    close_out();
  end
endmodule

`default_nettype wire
